// File: core/gpx_edge_irq.sv
// port A edge interrupt sources: pair choice and polarity per source
// assumes level_i comes from the pin synchroniser
`timescale 1ns/1ns
module gpx_edge_irq #(
  parameter int N = 4
) (
  input  wire logic           ref_clk_i,
  input  wire logic           resetn_i,
  input  wire logic [2*N-1:0] level_i,
  input  wire logic           valid_i,
  input  wire logic [N-1:0]   polarity_i,
  input  wire logic [N-1:0]   pair_i,
  output logic      [N-1:0]   event_o
);
  logic [2*N-1:0] prev_q;
  logic           armed_q;
  logic [N-1:0]   event_q;
  logic [N-1:0]   event_d;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_q  <= '0;
      armed_q <= 1'b0;
    end else begin
      prev_q  <= level_i;
      armed_q <= valid_i;
    end
  end

  for (genvar i = 0; i < N; i++) begin : g_src
    wire cur = pair_i[i] ? level_i[i+N] : level_i[i];
    wire old = pair_i[i] ? prev_q[i+N] : prev_q[i];
    // edge is a change between consecutive synchronised samples
    assign event_d[i] = armed_q & (polarity_i[i] ? (~old & cur) : (old & ~cur));
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      event_q <= '0;
    end else begin
      event_q <= event_d;
    end
  end

  assign event_o = event_q;
endmodule

// File: core/gpx_port.sv
// general-purpose port unit: data registers, port A edge interrupts,
// alternate function 1 selects and subregisters behind address/control pairs
// assumes a single-cycle register bus on ref_clk_i and asynchronous pins
//
// Notes on behaviour
// - edge polarity bit 0 requests on falling edge, 1 on rising edge
// - pair choice bit 0 takes line 0-3, 1 takes line four higher
// - pair choice at port A index 09 via A or C control; bits 7-4 read zero
// - port B alternate route reached via port B control at index 08
// - port A alternate route reached via A or C control at index 07
// - alternate route bit 1 routes pin to alternate function; resets zero
// - input registers return synchronised pin levels; read only
// - drive bit reaches pin only when output and not alternate function
// - open-drain pin never drives high; low still driven
// - edge polarity at port A index 08 via A or C control; low four bits
// - event sets pending bit; cleared by vector acknowledge or written zero
`timescale 1ns/1ns
`include "gpx_regs.svh"
module gpx_port #(
  parameter int PORTS = 3,
  parameter int NSRC  = 4
) (
  input  wire logic               ref_clk_i,
  input  wire logic               resetn_i,
  input  wire gpx_pkg::gpx_addr_t reg_addr_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  input  wire gpx_pkg::gpx_byte_t reg_wdata_i,
  output gpx_pkg::gpx_byte_t      reg_rdata_o,
  input  wire logic [23:0]        pin_in_i,
  output logic      [23:0]        pin_out_o,
  output logic      [23:0]        pin_oe_o,
  input  wire logic [23:0]        port_dir_out_i,
  input  wire logic [23:0]        port_open_drain_i,
  output logic      [15:0]        alt_route_one_o,
  input  wire logic [3:0]         irq_ack_i,
  output logic      [3:0]         irq_pend_o
);
  import gpx_pkg::*;

  // software-visible state
  gpx_byte_t pa_addr_q;
  gpx_byte_t pb_addr_q;
  gpx_byte_t pc_addr_q;
  gpx_byte_t pa_drive_q;
  gpx_byte_t pb_drive_q;
  gpx_byte_t pc_drive_q;
  gpx_nib_t  edge_polarity_q;
  gpx_nib_t  line_pair_q;
  gpx_byte_t alt_a_q;
  gpx_byte_t alt_b_q;
  gpx_nib_t  irq_pend_q;
  gpx_byte_t rdata_q;
  logic [23:0] pin_out_q;
  logic [23:0] pin_oe_q;
  logic [15:0] alt_q;

  // synchronised pins
  logic [23:0] level;
  logic        level_valid;
  gpx_nib_t    edge_event;

  gpx_sync #(
    .W (24)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .pin_i     (pin_in_i),
    .level_o   (level),
    .valid_o   (level_valid)
  );

  gpx_edge_irq #(
    .N (NSRC)
  ) u_edge (
    .ref_clk_i  (ref_clk_i),
    .resetn_i   (resetn_i),
    .level_i    (level[7:0]),
    .valid_i    (level_valid),
    .polarity_i (edge_polarity_q),
    .pair_i     (line_pair_q),
    .event_o    (edge_event)
  );

  // address decode
  wire hit_pa_addr = (reg_addr_i == `GPX_PA_ADDR);
  wire hit_pb_addr = (reg_addr_i == `GPX_PB_ADDR);
  wire hit_pc_addr = (reg_addr_i == `GPX_PC_ADDR);
  wire hit_pa_ctrl = (reg_addr_i == `GPX_PA_CTRL);
  wire hit_pb_ctrl = (reg_addr_i == `GPX_PB_CTRL);
  wire hit_pc_ctrl = (reg_addr_i == `GPX_PC_CTRL);
  wire hit_pa_out  = (reg_addr_i == `GPX_PA_OUT);
  wire hit_pb_out  = (reg_addr_i == `GPX_PB_OUT);
  wire hit_pc_out  = (reg_addr_i == `GPX_PC_OUT);
  wire hit_pa_in   = (reg_addr_i == `GPX_PA_IN);
  wire hit_pb_in   = (reg_addr_i == `GPX_PB_IN);
  wire hit_pc_in   = (reg_addr_i == `GPX_PC_IN);
  wire hit_irq     = (reg_addr_i == `GPX_IRQ_REQ);

  // port A and port C control both open the port A subregister window
  wire ac_ctrl     = hit_pa_ctrl | hit_pc_ctrl;
  wire sel_edge    = ac_ctrl & (pa_addr_q == `GPX_SUB_EDGE);
  wire sel_pair    = ac_ctrl & (pa_addr_q == `GPX_SUB_PAIR);
  wire sel_alt_a   = ac_ctrl & (pa_addr_q == `GPX_SUB_AF1_A);
  wire sel_alt_b   = hit_pb_ctrl & (pb_addr_q == `GPX_SUB_AF1_B);

  wire wr_edge     = reg_wr_i & sel_edge;
  wire wr_pair     = reg_wr_i & sel_pair;
  wire wr_alt_a    = reg_wr_i & sel_alt_a;
  wire wr_alt_b    = reg_wr_i & sel_alt_b;
  wire wr_irq      = reg_wr_i & hit_irq;
  wire wr_pa_addr  = reg_wr_i & hit_pa_addr;
  wire wr_pb_addr  = reg_wr_i & hit_pb_addr;
  wire wr_pc_addr  = reg_wr_i & hit_pc_addr;
  wire wr_pa_out   = reg_wr_i & hit_pa_out;
  wire wr_pb_out   = reg_wr_i & hit_pb_out;
  wire wr_pc_out   = reg_wr_i & hit_pc_out;

  // window index registers
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pa_addr_q <= `GPX_RST_BYTE;
    end else if (wr_pa_addr) begin
      pa_addr_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pb_addr_q <= `GPX_RST_BYTE;
    end else if (wr_pb_addr) begin
      pb_addr_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pc_addr_q <= `GPX_RST_BYTE;
    end else if (wr_pc_addr) begin
      pc_addr_q <= reg_wdata_i;
    end
  end

  // drive value registers
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pa_drive_q <= `GPX_RST_BYTE;
    end else if (wr_pa_out) begin
      pa_drive_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pb_drive_q <= `GPX_RST_BYTE;
    end else if (wr_pb_out) begin
      pb_drive_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pc_drive_q <= `GPX_RST_BYTE;
    end else if (wr_pc_out) begin
      pc_drive_q <= reg_wdata_i;
    end
  end

  // subregisters
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      edge_polarity_q <= `GPX_RST_NIBBLE;
    end else if (wr_edge) begin
      edge_polarity_q <= reg_wdata_i[3:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      line_pair_q <= `GPX_RST_NIBBLE;
    end else if (wr_pair) begin
      line_pair_q <= reg_wdata_i[3:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      alt_a_q <= `GPX_RST_BYTE;
    end else if (wr_alt_a) begin
      alt_a_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      alt_b_q <= `GPX_RST_BYTE;
    end else if (wr_alt_b) begin
      alt_b_q <= reg_wdata_i;
    end
  end

  // pending requests: event sets, acknowledge or written zero clears, set wins
  wire [3:0] irq_clr = irq_ack_i | (wr_irq ? ~reg_wdata_i[3:0] : 4'h0);
  wire [3:0] irq_nxt = (irq_pend_q & ~irq_clr) | edge_event;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_pend_q <= `GPX_RST_NIBBLE;
    end else begin
      irq_pend_q <= irq_nxt;
    end
  end

  // read data, one cycle after the read strobe
  wire [7:0] rd_pair = {4'h0, line_pair_q};
  wire [7:0] rd_edge = {4'h0, edge_polarity_q};
  wire [7:0] rd_irq  = {4'h0, irq_pend_q};
  logic [7:0] rd_mux;

  // data registers first, then the subregister windows
  always_comb begin
    if (hit_pa_in) begin
      rd_mux = level[7:0];
    end else if (hit_pb_in) begin
      rd_mux = level[15:8];
    end else if (hit_pc_in) begin
      rd_mux = level[23:16];
    end else if (hit_pa_out) begin
      rd_mux = pa_drive_q;
    end else if (hit_pb_out) begin
      rd_mux = pb_drive_q;
    end else if (hit_pc_out) begin
      rd_mux = pc_drive_q;
    end else if (hit_pa_addr) begin
      rd_mux = pa_addr_q;
    end else if (hit_pb_addr) begin
      rd_mux = pb_addr_q;
    end else if (hit_pc_addr) begin
      rd_mux = pc_addr_q;
    end else if (sel_edge) begin
      rd_mux = rd_edge;
    end else if (sel_pair) begin
      rd_mux = rd_pair;
    end else if (sel_alt_a) begin
      rd_mux = alt_a_q;
    end else if (sel_alt_b) begin
      rd_mux = alt_b_q;
    end else if (hit_irq) begin
      rd_mux = rd_irq;
    end else begin
      rd_mux = 8'h00;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= `GPX_RST_BYTE;
    end else if (reg_rd_i) begin
      rdata_q <= rd_mux;
    end
  end

  // pin drive per port; port C has no alternate route here
  wire [23:0] drive_all = {pc_drive_q, pb_drive_q, pa_drive_q};
  wire [23:0] alt_all   = {8'h00, alt_b_q, alt_a_q};
  logic [23:0] oe_d;
  localparam int NPIN = 8 * PORTS;

  for (genvar p = 0; p < NPIN; p++) begin : g_pin
    wire gp_drive = port_dir_out_i[p] & ~alt_all[p];
    // open drain: only the low level is actively driven
    assign oe_d[p] = gp_drive & (~port_open_drain_i[p] | ~drive_all[p]);
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_out_q <= 24'h00_0000;
    end else begin
      pin_out_q <= drive_all;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_oe_q <= 24'h00_0000;
    end else begin
      pin_oe_q <= oe_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      alt_q <= 16'h0000;
    end else begin
      alt_q <= alt_all[15:0];
    end
  end

  assign reg_rdata_o     = rdata_q;
  assign pin_out_o       = pin_out_q;
  assign pin_oe_o        = pin_oe_q;
  assign alt_route_one_o = alt_q;
  assign irq_pend_o      = irq_pend_q;
endmodule

// File: core/gpx_sync.sv
// three-flop pin synchroniser with agreement filter
// assumes pins are asynchronous to ref_clk_i
`timescale 1ns/1ns
`include "gpx_regs.svh"
module gpx_sync #(
  parameter int W = 8
) (
  input  wire logic         ref_clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o,
  output logic              valid_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] level_q;
  logic [1:0]   fill_q;
  logic         valid_q;
  wire          filled = (fill_q == `GPX_SYNC_FILL);
  wire  [W-1:0] agree  = ~(s2_q ^ s3_q);

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      fill_q  <= 2'h0;
      valid_q <= 1'b0;
    end else begin
      s1_q    <= pin_i;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      fill_q  <= filled ? fill_q : fill_q + 2'h1;
      valid_q <= valid_q | filled;
    end
  end

  // a bit changes only when second and third stage agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        level_q[i] <= 1'b0;
      end else if (filled && agree[i]) begin
        level_q[i] <= s3_q[i];
      end
    end
  end

  assign level_o = level_q;
  assign valid_o = valid_q & ~(~filled);
endmodule

// File: shared/gpx_pkg.sv
// types shared by the port block files
// assumes gpx_regs.svh carries all numeric constants
package gpx_pkg;
  typedef logic [7:0]  gpx_byte_t;
  typedef logic [11:0] gpx_addr_t;
  typedef logic [3:0]  gpx_nib_t;
endpackage

// File: shared/gpx_regs.svh
// register offsets, subregister indices, reset values and timing counts
// for the general-purpose port block; definitions only
`ifndef GPX_REGS_SVH
`define GPX_REGS_SVH

// port address and control registers
`define GPX_PA_ADDR      12'hfd0
`define GPX_PA_CTRL      12'hfd1
`define GPX_PB_ADDR      12'hfd4
`define GPX_PB_CTRL      12'hfd5
`define GPX_PC_ADDR      12'hfd8
`define GPX_PC_CTRL      12'hfd9

// data registers
`define GPX_PA_IN        12'hfd2
`define GPX_PA_OUT       12'hfd3
`define GPX_PB_IN        12'hfd6
`define GPX_PB_OUT       12'hfd7
`define GPX_PC_IN        12'hfda
`define GPX_PC_OUT       12'hfdb

// pending interrupt requests of the four port A edge sources
`define GPX_IRQ_REQ      12'hfc0

// subregister indices held in the port address registers
`define GPX_SUB_AF1_A    8'h07
`define GPX_SUB_EDGE     8'h08
`define GPX_SUB_PAIR     8'h09
`define GPX_SUB_AF1_B    8'h08

// field layout and reset values
`define GPX_LOW_NIBBLE   8'h0f
`define GPX_RST_BYTE     8'h00
`define GPX_RST_NIBBLE   4'h0

// pin synchroniser: flops to fill before a sample is trusted
`define GPX_SYNC_FILL    2'h3

`endif

// File: verification/gpx_pin_model.sv
// pin side model: outside levels resolved against the port's own drive
// assumes the bench changes outside levels off the clock edge
`timescale 1ns/1ns
module gpx_pin_model (
  input  wire logic [23:0] ext_level_i,
  input  wire logic [23:0] pin_out_i,
  input  wire logic [23:0] pin_oe_i,
  output logic      [23:0] pin_level_o
);
  // released or open-drain high pins show the outside level
  assign pin_level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_level_i);
endmodule

// File: verification/gpx_port_sva.sv
// checker for the port block: bus, drive and interrupt relations at top ports
// assumes a single-cycle register bus and asynchronous pins
`timescale 1ns/1ns
`include "gpx_regs.svh"
module gpx_port_sva #(
  parameter int PORTS = 3,
  parameter int NSRC  = 4
) (
  input wire logic               ref_clk_i,
  input wire logic               resetn_i,
  input wire gpx_pkg::gpx_addr_t reg_addr_i,
  input wire logic               reg_wr_i,
  input wire logic               reg_rd_i,
  input wire gpx_pkg::gpx_byte_t reg_wdata_i,
  input wire gpx_pkg::gpx_byte_t reg_rdata_o,
  input wire logic [23:0]        pin_in_i,
  input wire logic [23:0]        pin_out_o,
  input wire logic [23:0]        pin_oe_o,
  input wire logic [23:0]        port_dir_out_i,
  input wire logic [23:0]        port_open_drain_i,
  input wire logic [15:0]        alt_route_one_o,
  input wire logic [3:0]         irq_ack_i,
  input wire logic [3:0]         irq_pend_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence drive_cfg_held;
    ($stable(port_dir_out_i) && $stable(port_open_drain_i) && $stable(pin_out_o))[*3];
  endsequence
  sequence pins_c_held;
    ($stable(pin_in_i[23:16]))[*6];
  endsequence
  chk_c_drive_enable: assert property (
    drive_cfg_held |-> pin_oe_o[23:16] ==
      (port_dir_out_i[23:16] & ~(port_open_drain_i[23:16] & pin_out_o[23:16])))
    else $error("port C output enable wrong");
  chk_no_od_high: assert property (
    (pin_oe_o & pin_out_o & port_open_drain_i & $past(port_open_drain_i)
      & ~(pin_out_o ^ $past(pin_out_o))) == '0)
    else $error("open drain pin driven high");
  chk_alt_blocks_oe: assert property (
    (alt_route_one_o & $past(alt_route_one_o) & pin_oe_o[15:0]) == '0)
    else $error("alternate pin still driven");
  chk_out_write: assert property (
    reg_wr_i && reg_addr_i == `GPX_PA_OUT |-> ##2 pin_out_o[7:0] == $past(reg_wdata_i, 2))
    else $error("port A drive value not taken");
  chk_rdata_hold: assert property (
    !$past(reg_rd_i) |-> $stable(reg_rdata_o))
    else $error("read data changed without read");
  chk_pend_clear: assert property (
    (~irq_pend_o & $past(irq_pend_o) & ~$past(irq_ack_i)) != '0
      |-> $past(reg_wr_i) && $past(reg_addr_i) == `GPX_IRQ_REQ)
    else $error("pending bit lost without clear");
  chk_pend_cause: assert property (
    (irq_pend_o & ~$past(irq_pend_o)) != '0
      |-> $past(pin_in_i[7:0], 3) != $past(pin_in_i[7:0], 10))
    else $error("pending bit set without pin change");
  chk_pin_read_c: assert property (
    pins_c_held ##0 (reg_rd_i && reg_addr_i == `GPX_PC_IN && $past(resetn_i, 8))
      |=> reg_rdata_o == $past(pin_in_i[23:16]))
    else $error("port C input read wrong");
  chk_unmapped_zero: assert property (
    reg_rd_i && reg_addr_i == 12'h000 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind gpx_port gpx_port_sva #(.PORTS(PORTS), .NSRC(NSRC)) u_sva (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
  .pin_oe_o(pin_oe_o), .port_dir_out_i(port_dir_out_i),
  .port_open_drain_i(port_open_drain_i), .alt_route_one_o(alt_route_one_o),
  .irq_ack_i(irq_ack_i), .irq_pend_o(irq_pend_o));

// File: verification/gpx_port_tb.sv
// self-checking bench for the port block: register tasks, pins, interrupts
// assumes gpx_port, gpx_pin_model and the bound checker
`timescale 1ns/1ns
`include "gpx_regs.svh"
module gpx_port_tb;
  import gpx_pkg::*;
  logic        ref_clk_i   = 1'b0;
  logic        resetn_i    = 1'b0;
  gpx_addr_t   reg_addr_i  = '0;
  logic        reg_wr_i    = 1'b0;
  logic        reg_rd_i    = 1'b0;
  gpx_byte_t   reg_wdata_i = '0;
  gpx_byte_t   reg_rdata_o;
  logic [23:0] pin_in_i, pin_out_o, pin_oe_o;
  logic [23:0] ext_level   = '0;
  logic [23:0] dir_out     = '0;
  logic [23:0] open_drain  = '0;
  logic [15:0] alt_route_one_o;
  logic [3:0]  irq_ack_i   = '0;
  logic [3:0]  irq_pend_o;
  int          n_mismatch  = 0;
  int          num_checks  = 0;
  int          cycles      = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  gpx_port dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
    .pin_oe_o(pin_oe_o), .port_dir_out_i(dir_out), .port_open_drain_i(open_drain),
    .alt_route_one_o(alt_route_one_o), .irq_ack_i(irq_ack_i), .irq_pend_o(irq_pend_o));
  gpx_pin_model pins (.ext_level_i(ext_level), .pin_out_i(pin_out_o),
    .pin_oe_i(pin_oe_o), .pin_level_o(pin_in_i));
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input gpx_addr_t a, input gpx_byte_t d);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input gpx_addr_t a, input gpx_byte_t e);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge ref_clk_i);
    #1 chk(24'(reg_rdata_o), 24'(e));
  endtask
  task automatic settle();
    repeat (10) @(posedge ref_clk_i);
    #1;
  endtask
  initial begin
    repeat (20) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    rd(`GPX_PA_OUT, 8'h00);
    rd(`GPX_PC_OUT, 8'h00);
    rd(`GPX_PB_OUT, 8'h00);
    for (int i = 7; i <= 9; i++) begin
      wr(`GPX_PA_ADDR, 8'(i));
      rd(`GPX_PA_CTRL, 8'h00);
    end
    wr(`GPX_PB_ADDR, `GPX_SUB_AF1_B);
    rd(`GPX_PB_ADDR, `GPX_SUB_AF1_B);
    rd(`GPX_PB_CTRL, 8'h00);
    $display("test reset values done");
    // alternate bits only on pins taken to carry a function
    wr(`GPX_PB_CTRL, 8'ha5);
    wr(`GPX_PA_ADDR, `GPX_SUB_PAIR);
    wr(`GPX_PC_CTRL, 8'hff);
    rd(`GPX_PA_CTRL, 8'h0f);
    wr(`GPX_PA_ADDR, `GPX_SUB_AF1_A);
    wr(`GPX_PA_CTRL, 8'h3c);
    rd(`GPX_PC_CTRL, 8'h3c);
    chk(24'(alt_route_one_o), 24'h00_a53c);
    rd(12'h000, 8'h00);
    $display("test subregisters done");
    @(posedge ref_clk_i);
    dir_out    <= 24'hff_ffff;
    open_drain <= 24'h0f_0000;
    wr(`GPX_PC_OUT, 8'hff);
    wr(`GPX_PA_OUT, 8'hff);
    settle();
    chk(pin_out_o, 24'hff_00ff);
    chk(pin_oe_o, 24'hf0_5ac3);
    $display("test drive done");
    @(posedge ref_clk_i);
    dir_out   <= '0;
    ext_level <= 24'h3c_c35a;
    settle();
    rd(`GPX_PA_IN, 8'h5a);
    rd(`GPX_PB_IN, 8'hc3);
    rd(`GPX_PC_IN, 8'h3c);
    $display("test input levels done");
    @(posedge ref_clk_i);
    ext_level <= '0;
    wr(`GPX_PA_ADDR, `GPX_SUB_EDGE);
    wr(`GPX_PA_CTRL, 8'h0f);
    wr(`GPX_PA_ADDR, `GPX_SUB_PAIR);
    wr(`GPX_PA_CTRL, 8'h00);
    settle();
    wr(`GPX_IRQ_REQ, 8'h00);
    ext_level <= 24'h00_0005;
    settle();
    chk(24'(irq_pend_o), 24'h00_0005);
    wr(`GPX_IRQ_REQ, 8'h0f);
    #1 chk(24'(irq_pend_o), 24'h00_0005);
    wr(`GPX_IRQ_REQ, 8'h04);
    #1 chk(24'(irq_pend_o), 24'h00_0004);
    @(posedge ref_clk_i);
    irq_ack_i <= 4'h4;
    @(posedge ref_clk_i);
    irq_ack_i <= 4'h0;
    settle();
    chk(24'(irq_pend_o), 24'h00_0000);
    wr(`GPX_PA_CTRL, 8'h0f);
    wr(`GPX_PA_ADDR, `GPX_SUB_EDGE);
    wr(`GPX_PA_CTRL, 8'h00);
    settle();
    wr(`GPX_IRQ_REQ, 8'h00);
    ext_level <= 24'h00_00f5;
    settle();
    chk(24'(irq_pend_o), 24'h00_0000);
    @(posedge ref_clk_i);
    ext_level <= 24'h00_00f0;
    settle();
    chk(24'(irq_pend_o), 24'h00_0000);
    @(posedge ref_clk_i);
    ext_level <= 24'h00_0000;
    settle();
    chk(24'(irq_pend_o), 24'h00_000f);
    $display("test edge requests done");
    end_sim();
  end
endmodule
